// >>> hdl/fer_map.svh
`ifndef FER_MAP_SVH
`define FER_MAP_SVH

// record geometry
`define FER_DEPTH 3'h5
`define FER_REC_STRIDE 5'h10
`define FER_REC_LAST 7'h4F

// record word offsets within one record
`define FER_F_IA_MAIN 4'h0
`define FER_F_IA_SUB 4'h1
`define FER_F_IB_MAIN 4'h2
`define FER_F_IB_SUB 4'h3
`define FER_F_IC_MAIN 4'h4
`define FER_F_IC_SUB 4'h5
`define FER_F_IN_MAIN 4'h6
`define FER_F_IN_SUB 4'h7
`define FER_F_UNBAL 4'h8
`define FER_F_TH_START 4'h9
`define FER_F_TH_MAX 4'hA
`define FER_F_DUR_LO 4'hB
`define FER_F_DUR_HI 4'hC
`define FER_F_MISC 4'hD
`define FER_F_DATE 4'hE
`define FER_F_TIME 4'hF

// control and counter word indices
`define FER_A_CTRL 7'h50
`define FER_A_CNT_CLEAR 7'h51
`define FER_A_IRQ_STATUS 7'h52
`define FER_A_IRQ_MASK 7'h53
`define FER_A_STATUS 7'h54
`define FER_A_START_CNT 7'h58
`define FER_A_TRIP_CNT 7'h60
`define FER_A_SHOT_CNT 7'h70

// field positions and values
`define FER_CTRL_MRESET 0
`define FER_IRQ_COMMIT 0
`define FER_IRQ_DROP 1
`define FER_CLR_TRIPS 32'h0000_0001
`define FER_CLR_SHOTS 32'h0000_0002

// limits and reset values
`define FER_PCT_FULL 7'h64
`define FER_PCT_BLOCKED 7'h63
`define FER_THERM_OFF 10'h3E7
`define FER_START_MAX 10'h3E7
`define FER_SHOT_MAX 8'hFF
`define FER_ORD_FIRST 8'h01
`define FER_ZERO32 32'h0000_0000

`endif

// >>> hdl/fer_pkg.sv
package fer_pkg;
    typedef enum logic [1:0] {FER_IDLE, FER_COLLECT, FER_HOLD} fer_state_t;

    typedef struct packed {
        logic [3:0][15:0] cur_main;
        logic [3:0][15:0] cur_sub;
        logic [7:0] unbal;
        logic [9:0] th_start;
        logic [9:0] th_max;
        logic [8:0][6:0] dur;
        logic [7:0] trip_no;
        logic [23:0] date;
        logic [39:0] tod;
    } fer_rec_t;
endpackage : fer_pkg

// >>> hdl/fer_stage_if.sv
`timescale 1ns/10ps
interface fer_stage_if;
    logic start;
    logic trip;
    logic blocked;
    logic [6:0] progress;
    modport drv (output start, output trip, output blocked, output progress);
    modport rec (input start, input trip, input blocked, input progress);
endinterface : fer_stage_if

// >>> hdl/fer_duration.sv
`timescale 1ns/10ps
`include "fer_map.svh"
module fer_duration (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic clear,
    // stage view
    fer_stage_if.rec stg,
    // running duration, percent of operate time
    output logic [6:0] dur
);
    logic [6:0] dur_q;
    logic [6:0] cand;

    always_comb begin
        cand = 7'h00;
        if (stg.start || stg.trip) begin
            if (stg.progress >= `FER_PCT_FULL) begin
                cand = stg.blocked ? `FER_PCT_BLOCKED : `FER_PCT_FULL;
            end else begin
                // never zero once started, so the record shows the start
                cand = (stg.progress == 7'h00) ? 7'h01 : stg.progress;
            end
            if (stg.trip && !stg.blocked) begin
                cand = `FER_PCT_FULL;
            end
        end
        dur = (cand > dur_q) ? cand : dur_q;
    end

    always_ff @(posedge clk) begin
        if (rst || clear) begin
            dur_q <= 7'h00;
        end else begin
            dur_q <= dur;
        end
    end
endmodule : fer_duration

// >>> hdl/fer_recorder.sv
`timescale 1ns/10ps
`include "fer_map.svh"
module fer_recorder (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // avalon-mm slave, word addressed
    input wire logic [6:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // measurements
    input wire logic [3:0][15:0] cur,
    input wire logic [7:0] unbal,
    input wire logic [9:0] therm_level,
    input wire logic therm_enabled,
    input wire logic therm_alarm,
    input wire logic therm_trip,
    // protection stages
    input wire logic [5:0] stage_start,
    input wire logic [8:0] stage_trip,
    input wire logic [8:0] stage_blocked,
    input wire logic [8:0][6:0] stage_progress,
    // auto-reclose function
    input wire logic ar_enabled,
    input wire logic ar_reclaim_done,
    input wire logic ar_open_cmd,
    input wire logic [11:0] ar_shot,
    // real-time clock
    input wire logic [23:0] rtc_date,
    input wire logic [39:0] rtc_time,
    // outputs to the relay
    output logic master_reset_pulse,
    output logic therm_dashes,
    output logic irq
);
    import fer_pkg::*;

    localparam int START_MAP [5] = '{0, 1, 3, 4, 5};

    fer_state_t state;
    fer_rec_t recs [5];
    fer_rec_t next_rec;
    logic [2:0] rec_count;
    logic [3:0][15:0] peak;
    logic [7:0] unbal_pk;
    logic [9:0] th_start;
    logic [9:0] th_max;
    logic [7:0] trip_seq;
    logic trip_q;
    logic [5:0] start_q;
    logic [10:0] tcnt_q;
    logic [11:0] shot_q;
    logic [4:0][9:0] start_cnt;
    logic [10:0][15:0] trip_cnt;
    logic [11:0][7:0] shot_cnt;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic ack;
    logic wr_go;
    logic mreset;
    logic clr_trips;
    logic clr_shots;
    logic active;
    logic trip_any;
    logic trip_rise;
    logic commit;
    logic commit_trip;
    logic capture_clear;
    logic [10:0] trip_vec;
    logic [8:0][6:0] dur_w;
    logic [31:0] rd_word;

    // ---------------- bus slave ----------------
    // one wait state: data is registered on the first cycle of the request
    assign avs_waitrequest = (avs_read || avs_write) && !ack;
    assign wr_go = avs_write && !avs_waitrequest;
    assign mreset = wr_go && (avs_address == `FER_A_CTRL) &&
                    avs_writedata[`FER_CTRL_MRESET];
    assign clr_trips = wr_go && (avs_address == `FER_A_CNT_CLEAR) &&
                       (avs_writedata == `FER_CLR_TRIPS);
    assign clr_shots = wr_go && (avs_address == `FER_A_CNT_CLEAR) &&
                       (avs_writedata == `FER_CLR_SHOTS);

    always_ff @(posedge clk) begin
        if (rst) begin
            ack <= 1'b0;
        end else begin
            ack <= (avs_read || avs_write) && !ack;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            avs_readdata <= `FER_ZERO32;
        end else if (avs_read && !ack) begin
            avs_readdata <= rd_word;
        end
    end

    function automatic logic [31:0] rec_word(input fer_rec_t r, input logic [3:0] f,
                                              input logic th_on);
        logic [31:0] w;
        w = `FER_ZERO32;
        case (f)
            `FER_F_IA_MAIN: w = {16'h0000, r.cur_main[0]};
            `FER_F_IA_SUB: w = {16'h0000, r.cur_sub[0]};
            `FER_F_IB_MAIN: w = {16'h0000, r.cur_main[1]};
            `FER_F_IB_SUB: w = {16'h0000, r.cur_sub[1]};
            `FER_F_IC_MAIN: w = {16'h0000, r.cur_main[2]};
            `FER_F_IC_SUB: w = {16'h0000, r.cur_sub[2]};
            `FER_F_IN_MAIN: w = {16'h0000, r.cur_main[3]};
            `FER_F_IN_SUB: w = {16'h0000, r.cur_sub[3]};
            `FER_F_UNBAL: w = {24'h00_0000, r.unbal};
            `FER_F_TH_START: w = {22'h00_0000, th_on ? r.th_start : `FER_THERM_OFF};
            `FER_F_TH_MAX: w = {22'h00_0000, th_on ? r.th_max : `FER_THERM_OFF};
            `FER_F_DUR_LO: w = {1'b0, r.dur[3], 1'b0, r.dur[2], 1'b0, r.dur[1],
                                1'b0, r.dur[0]};
            `FER_F_DUR_HI: w = {1'b0, r.dur[7], 1'b0, r.dur[6], 1'b0, r.dur[5],
                                1'b0, r.dur[4]};
            `FER_F_MISC: w = {r.tod[15:0], r.trip_no, 1'b0, r.dur[8]};
            `FER_F_DATE: w = {8'h00, r.date};
            `FER_F_TIME: w = {8'h00, r.tod[39:16]};
            default: w = `FER_ZERO32;
        endcase
        return w;
    endfunction : rec_word

    always_comb begin
        rd_word = `FER_ZERO32;
        if (avs_address <= `FER_REC_LAST) begin
            rd_word = rec_word(recs[avs_address[6:4]], avs_address[3:0], therm_enabled);
        end else if (avs_address == `FER_A_IRQ_STATUS) begin
            rd_word = {30'h0000_0000, irq_status};
        end else if (avs_address == `FER_A_IRQ_MASK) begin
            rd_word = {30'h0000_0000, irq_mask};
        end else if (avs_address == `FER_A_STATUS) begin
            rd_word = {23'h00_0000, state != FER_IDLE, 5'h00, rec_count};
        end else if (avs_address >= `FER_A_START_CNT &&
                     avs_address < `FER_A_START_CNT + 7'h05) begin
            rd_word = {22'h00_0000, start_cnt[3'(avs_address - `FER_A_START_CNT)]};
        end else if (avs_address >= `FER_A_TRIP_CNT &&
                     avs_address < `FER_A_TRIP_CNT + 7'h0B) begin
            rd_word = {16'h0000, trip_cnt[4'(avs_address - `FER_A_TRIP_CNT)]};
        end else if (avs_address >= `FER_A_SHOT_CNT &&
                     avs_address < `FER_A_SHOT_CNT + 7'h03) begin
            rd_word = shot_cnt[2'(avs_address - `FER_A_SHOT_CNT) * 4 +: 4];
        end
    end

    // ---------------- fault capture ----------------
    assign active = (|stage_start) || therm_alarm;
    assign trip_any = (|stage_trip) || therm_trip;
    assign trip_rise = trip_any && !trip_q;
    assign therm_dashes = !therm_enabled;
    assign master_reset_pulse = mreset;

    // a trip commits at once; the fault may keep starts up, so hold until it clears
    always_comb begin
        commit = 1'b0;
        commit_trip = 1'b0;
        case (state)
            FER_IDLE: begin
                commit_trip = trip_rise;
            end
            FER_COLLECT: begin
                commit_trip = trip_rise;
                commit = !trip_rise && !active;
            end
            FER_HOLD: begin
                commit_trip = 1'b0;
            end
            default: begin
                commit_trip = 1'b0;
            end
        endcase
        commit = commit || commit_trip;
    end

    assign capture_clear = commit || mreset;

    always_ff @(posedge clk) begin
        if (rst || mreset) begin
            state <= FER_IDLE;
        end else begin
            case (state)
                FER_IDLE: begin
                    if (trip_rise) begin
                        state <= FER_HOLD;
                    end else if (active) begin
                        state <= FER_COLLECT;
                    end
                end
                FER_COLLECT: begin
                    if (trip_rise) begin
                        state <= FER_HOLD;
                    end else if (!active) begin
                        state <= FER_IDLE;
                    end
                end
                FER_HOLD: begin
                    if (!active && !trip_any) begin
                        state <= FER_IDLE;
                    end
                end
                default: begin
                    state <= FER_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            trip_q <= 1'b0;
        end else begin
            trip_q <= trip_any;
        end
    end

    // running maxima over pick-up
    always_ff @(posedge clk) begin
        if (rst || capture_clear) begin
            peak <= '0;
            unbal_pk <= 8'h00;
            th_start <= 10'h000;
            th_max <= 10'h000;
        end else if (active && state != FER_HOLD) begin
            for (int i = 0; i < 4; i++) begin
                if (cur[i] > peak[i]) begin
                    peak[i] <= cur[i];
                end
            end
            if (unbal > unbal_pk) begin
                unbal_pk <= unbal;
            end
            if (state == FER_IDLE) begin
                th_start <= therm_level;
            end
            if (therm_level > th_max) begin
                th_max <= therm_level;
            end
        end
    end

    // record assembled from the capture plus this cycle's samples
    always_comb begin
        next_rec = '0;
        for (int i = 0; i < 4; i++) begin
            next_rec.cur_sub[i] = (cur[i] > peak[i]) ? cur[i] : peak[i];
            next_rec.cur_main[i] = commit_trip ? cur[i] : next_rec.cur_sub[i];
        end
        if (commit_trip) begin
            next_rec.unbal = unbal;
            next_rec.th_max = therm_level;
        end else begin
            next_rec.unbal = (unbal > unbal_pk) ? unbal : unbal_pk;
            next_rec.th_max = (therm_level > th_max) ? therm_level : th_max;
        end
        next_rec.th_start = (state == FER_COLLECT) ? th_start : therm_level;
        next_rec.dur = dur_w;
        if (!commit_trip) begin
            next_rec.trip_no = 8'h00;
        end else if (!ar_enabled) begin
            next_rec.trip_no = `FER_ORD_FIRST;
        end else begin
            next_rec.trip_no = trip_seq + 8'h01;
        end
        next_rec.date = rtc_date;
        next_rec.tod = rtc_time;
    end

    // ordinal of the trip within the reclose sequence
    always_ff @(posedge clk) begin
        if (rst || ar_reclaim_done || !ar_enabled) begin
            trip_seq <= 8'h00;
        end else if (commit_trip && trip_seq != `FER_SHOT_MAX) begin
            trip_seq <= trip_seq + 8'h01;
        end
    end

    // ---------------- history ----------------
    always_ff @(posedge clk) begin
        if (rst || mreset) begin
            for (int i = 0; i < 5; i++) begin
                recs[i] <= '0;
            end
            rec_count <= 3'h0;
        end else if (commit) begin
            recs[0] <= next_rec;
            for (int i = 1; i < 5; i++) begin
                recs[i] <= recs[i - 1];
            end
            if (rec_count != `FER_DEPTH) begin
                rec_count <= rec_count + 3'h1;
            end
        end
    end

    // ---------------- stage durations ----------------
    for (genvar g = 0; g < 9; g++) begin : g_stage
        fer_stage_if sif ();
        assign sif.start = (g < 6) ? stage_start[g % 6] : 1'b0;
        assign sif.trip = stage_trip[g];
        assign sif.blocked = stage_blocked[g];
        assign sif.progress = stage_progress[g];
        fer_duration u_dur (
            .clk(clk),
            .rst(rst),
            .clear(capture_clear || state == FER_HOLD),
            .stg(sif.rec),
            .dur(dur_w[g])
        );
    end

    // ---------------- counters ----------------
    assign trip_vec = {ar_open_cmd, therm_trip, stage_trip};

    always_ff @(posedge clk) begin
        if (rst) begin
            start_q <= 6'h00;
            tcnt_q <= 11'h000;
            shot_q <= 12'h000;
        end else begin
            start_q <= stage_start;
            tcnt_q <= trip_vec;
            shot_q <= ar_shot;
        end
    end

    for (genvar s = 0; s < 5; s++) begin : g_start
        always_ff @(posedge clk) begin
            if (rst || mreset) begin
                start_cnt[s] <= 10'h000;
            end else if (stage_start[START_MAP[s]] && !start_q[START_MAP[s]] &&
                         start_cnt[s] != `FER_START_MAX) begin
                start_cnt[s] <= start_cnt[s] + 10'h001;
            end
        end
    end

    // rst stands in for the load from non-volatile store; master reset does not touch these
    for (genvar t = 0; t < 11; t++) begin : g_trip
        always_ff @(posedge clk) begin
            if (rst || clr_trips) begin
                trip_cnt[t] <= 16'h0000;
            end else if (trip_vec[t] && !tcnt_q[t]) begin
                trip_cnt[t] <= trip_cnt[t] + 16'h0001;
            end
        end
    end

    for (genvar a = 0; a < 12; a++) begin : g_shot
        always_ff @(posedge clk) begin
            if (rst || clr_shots) begin
                shot_cnt[a] <= 8'h00;
            end else if (ar_shot[a] && !shot_q[a] && shot_cnt[a] != `FER_SHOT_MAX) begin
                shot_cnt[a] <= shot_cnt[a] + 8'h01;
            end
        end
    end

    // ---------------- interrupts ----------------
    // a new event wins over a write-one-to-clear in the same cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_status <= 2'h0;
            irq_mask <= 2'h0;
        end else begin
            irq_status[`FER_IRQ_COMMIT] <= commit ||
                (irq_status[`FER_IRQ_COMMIT] &&
                 !(wr_go && avs_address == `FER_A_IRQ_STATUS &&
                   avs_writedata[`FER_IRQ_COMMIT]));
            irq_status[`FER_IRQ_DROP] <= (commit && rec_count == `FER_DEPTH) ||
                (irq_status[`FER_IRQ_DROP] &&
                 !(wr_go && avs_address == `FER_A_IRQ_STATUS &&
                   avs_writedata[`FER_IRQ_DROP]));
            if (wr_go && avs_address == `FER_A_IRQ_MASK) begin
                irq_mask <= avs_writedata[1:0];
            end
        end
    end

    assign irq = |(irq_status & irq_mask);
endmodule : fer_recorder

// >>> sim/fer_asserts.sv
`timescale 1ns/10ps
`include "fer_map.svh"
module fer_asserts (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register bus
    input wire logic [6:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // relay side
    input wire logic therm_enabled,
    input wire logic master_reset_pulse,
    input wire logic therm_dashes,
    input wire logic irq
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    logic rd_ok;
    logic rec_rd;
    assign rd_ok = avs_read && !avs_waitrequest;
    assign rec_rd = rd_ok && avs_address <= `FER_REC_LAST;
    a_first_wait: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
        else $error("no wait state on new request");
    a_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("wait state longer than one cycle");
    a_idle_ready: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
        else $error("waitrequest while idle");
    a_dash_level: assert property (therm_dashes == !therm_enabled)
        else $error("dash indication wrong");
    a_therm_off: assert property (rec_rd && !therm_enabled && avs_address[3:0] inside {4'h9, 4'hA}
        |-> avs_readdata[9:0] == `FER_THERM_OFF)
        else $error("thermal field not 999");
    a_count_max: assert property (rd_ok && avs_address == `FER_A_STATUS
        |-> avs_readdata[2:0] <= `FER_DEPTH)
        else $error("record count above five");
    a_start_sat: assert property (rd_ok && avs_address >= `FER_A_START_CNT && avs_address <= 7'h5C
        |-> avs_readdata <= 32'h0000_03E7)
        else $error("start counter above 999");
    a_dur_pct: assert property (rec_rd && avs_address[3:0] == `FER_F_DUR_LO
        |-> avs_readdata[6:0] <= `FER_PCT_FULL && avs_readdata[14:8] <= `FER_PCT_FULL)
        else $error("duration above 100");
    a_mreset_src: assert property (master_reset_pulse
        |-> avs_write && avs_address == `FER_A_CTRL && avs_writedata[0])
        else $error("master reset without control write");
    a_mreset_one: assert property (master_reset_pulse |=> !master_reset_pulse)
        else $error("master reset pulse too long");
    a_irq_after_rst: assert property ($past(rst) |-> !irq)
        else $error("irq high after reset");
    a_irq_unmask: assert property (avs_write && !avs_waitrequest && avs_address == `FER_A_IRQ_MASK
        && avs_writedata == 32'h0000_0000 |=> !irq)
        else $error("irq high with mask cleared");
    c_mreset: cover property (master_reset_pulse);
    c_irq: cover property (irq);
    c_full: cover property (rd_ok && avs_address == `FER_A_STATUS && avs_readdata[2:0] == 3'h5);
endmodule : fer_asserts

bind fer_recorder fer_asserts u_chk (.*);

// >>> sim/fer_stage_model.sv
`timescale 1ns/10ps
module fer_stage_model (
    // clock
    input wire logic clk,
    // measurements
    output logic [3:0][15:0] cur,
    output logic [7:0] unbal,
    output logic [9:0] therm_level,
    output logic therm_alarm,
    output logic therm_trip,
    // stages
    output logic [5:0] stage_start,
    output logic [8:0] stage_trip,
    output logic [8:0] stage_blocked,
    output logic [8:0][6:0] stage_progress
);
    initial begin
        {cur, unbal, therm_level, therm_alarm, therm_trip} = '0;
        {stage_start, stage_trip, stage_blocked, stage_progress} = '0;
    end
    // one fault on stage 0: peak early, lower value later so peak and trip value differ
    task automatic fault(input logic [15:0] pk, input logic [15:0] at, input logic tr,
        input logic bl);
        @(posedge clk);
        stage_start[0] <= 1'b1;
        stage_blocked[0] <= bl;
        stage_progress[0] <= 7'h28;
        cur <= {4{pk}};
        unbal <= 8'h20;
        therm_level <= 10'h032;
        @(posedge clk);
        cur <= {4{at}};
        unbal <= 8'h10;
        therm_level <= 10'h040;
        if (tr || bl) stage_progress[0] <= 7'h64;
        repeat (2) @(posedge clk);
        stage_trip[0] <= tr;
        repeat (2) @(posedge clk);
        {stage_start, stage_trip, stage_blocked, stage_progress} <= '0;
        {cur, unbal, therm_level} <= '0;
        repeat (4) @(posedge clk);
    endtask : fault
endmodule : fer_stage_model

// >>> sim/fer_recorder_tb.sv
`timescale 1ns/10ps
`include "fer_map.svh"
module fer_recorder_tb;
    logic clk, rst, avs_read, avs_write, avs_waitrequest, mr_seen;
    logic [6:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [3:0][15:0] cur;
    logic [7:0] unbal;
    logic [9:0] therm_level;
    logic therm_enabled, therm_alarm, therm_trip, ar_open_cmd, ar_enabled, ar_reclaim_done;
    logic master_reset_pulse, therm_dashes, irq;
    logic [5:0] stage_start;
    logic [8:0] stage_trip, stage_blocked;
    logic [8:0][6:0] stage_progress;
    logic [11:0] ar_shot;
    logic [23:0] rtc_date;
    logic [39:0] rtc_time;
    int failures = 0;
    int total_checks = 0;
    fer_stage_model model (.*);
    fer_recorder dut (.*);
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) if (master_reset_pulse === 1'b1) mr_seen <= 1'b1;
    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : close_out
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic bus(input logic wr, input logic [6:0] a, input logic [31:0] d);
        int n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (avs_waitrequest !== 1'b0) begin
            failures++;
            close_out();
        end
        @(posedge clk);
    endtask : bus
    task automatic rd(input string nm, input logic [6:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        chk(nm, exp, q);
    endtask : rd
    function automatic logic [6:0] fa(input logic [2:0] n, input logic [3:0] f);
        return {n, f};
    endfunction : fa
    task automatic t_reset;
        rd("status", `FER_A_STATUS, 32'h0000_0000);
        rd("slot0", fa(3'h0, `FER_F_IA_MAIN), 32'h0000_0000);
        bus(1'b1, 7'h7F, 32'h0000_FFFF);
        rd("unmapped", 7'h7F, 32'h0000_0000);
    endtask : t_reset
    task automatic t_start;
        model.fault(16'h0300, 16'h0200, 1'b0, 1'b0);
        rd("ia_main", fa(3'h0, `FER_F_IA_MAIN), 32'h0000_0300);
        rd("in_sub", fa(3'h0, `FER_F_IN_SUB), 32'h0000_0300);
        rd("unbal", fa(3'h0, `FER_F_UNBAL), 32'h0000_0020);
        rd("th_start", fa(3'h0, `FER_F_TH_START), 32'h0000_0032);
        rd("th_max", fa(3'h0, `FER_F_TH_MAX), 32'h0000_0040);
        rd("date", fa(3'h0, `FER_F_DATE), 32'h0024_0611);
        rd("time", fa(3'h0, `FER_F_TIME), 32'h0012_3456);
        bus(1'b0, fa(3'h0, `FER_F_DUR_LO), 32'h0000_0000);
        chk("dur_start", 32'h0000_0001, {31'h0, q[6:0] != 7'h00 && q[6:0] < 7'h64});
        bus(1'b0, fa(3'h0, `FER_F_MISC), 32'h0000_0000);
        chk("trip_no", 32'h0000_0000, {24'h0, q[15:8]});
        rd("status", `FER_A_STATUS, 32'h0000_0001);
    endtask : t_start
    task automatic t_trip;
        model.fault(16'h0500, 16'h0400, 1'b1, 1'b0);
        rd("ia_main", fa(3'h0, `FER_F_IA_MAIN), 32'h0000_0400);
        rd("ib_sub", fa(3'h0, `FER_F_IB_SUB), 32'h0000_0500);
        rd("unbal", fa(3'h0, `FER_F_UNBAL), 32'h0000_0010);
        rd("th_trip", fa(3'h0, `FER_F_TH_MAX), 32'h0000_0040);
        bus(1'b0, fa(3'h0, `FER_F_MISC), 32'h0000_0000);
        chk("trip_no", 32'h0000_0001, {24'h0, q[15:8]});
        bus(1'b0, fa(3'h0, `FER_F_DUR_LO), 32'h0000_0000);
        chk("dur_trip", 32'h0000_0064, {25'h0, q[6:0]});
        rd("status", `FER_A_STATUS, 32'h0000_0002);
        rd("trip_cnt", `FER_A_TRIP_CNT, 32'h0000_0001);
    endtask : t_trip
    task automatic t_blocked;
        model.fault(16'h0700, 16'h0600, 1'b0, 1'b1);
        bus(1'b0, fa(3'h0, `FER_F_DUR_LO), 32'h0000_0000);
        chk("dur_block", 32'h0000_0063, {25'h0, q[6:0]});
        rd("ia_main", fa(3'h0, `FER_F_IA_MAIN), 32'h0000_0700);
    endtask : t_blocked
    task automatic t_therm_off;
        therm_enabled <= 1'b0;
        @(posedge clk);
        rd("th_start", fa(3'h0, `FER_F_TH_START), 32'h0000_03E7);
        rd("th_max", fa(3'h0, `FER_F_TH_MAX), 32'h0000_03E7);
        chk("dashes", 32'h0000_0001, {31'h0, therm_dashes});
        therm_enabled <= 1'b1;
        @(posedge clk);
    endtask : t_therm_off
    task automatic t_fill_irq;
        bus(1'b1, `FER_A_IRQ_MASK, 32'h0000_0002);
        bus(1'b1, `FER_A_IRQ_STATUS, 32'h0000_0003);
        chk("irq_clear", 32'h0000_0000, {31'h0, irq});
        rtc_date <= 24'h24_0612;
        for (logic [15:0] p = 16'h0101; p < 16'h0104; p++) model.fault(p, 16'h0080, 1'b0, 1'b0);
        chk("irq_drop", 32'h0000_0001, {31'h0, irq});
        rd("irq_status", `FER_A_IRQ_STATUS, 32'h0000_0003);
        bus(1'b1, `FER_A_IRQ_STATUS, 32'h0000_0002);
        chk("irq_masked", 32'h0000_0000, {31'h0, irq});
        rd("status", `FER_A_STATUS, 32'h0000_0005);
        rd("slot0", fa(3'h0, `FER_F_IA_MAIN), 32'h0000_0103);
        rd("slot2", fa(3'h2, `FER_F_IA_MAIN), 32'h0000_0101);
        rd("slot4", fa(3'h4, `FER_F_IA_MAIN), 32'h0000_0400);
        rd("slot4_sub", fa(3'h4, `FER_F_IA_SUB), 32'h0000_0500);
        rd("date", fa(3'h0, `FER_F_DATE), 32'h0024_0612);
        rd("starts", `FER_A_START_CNT, 32'h0000_0006);
    endtask : t_fill_irq
    task automatic t_mreset;
        bus(1'b1, `FER_A_CTRL, 32'h0000_0001);
        chk("mreset", 32'h0000_0001, {31'h0, mr_seen});
        rd("slot0", fa(3'h0, `FER_F_IA_MAIN), 32'h0000_0000);
        rd("status", `FER_A_STATUS, 32'h0000_0000);
        rd("starts", `FER_A_START_CNT, 32'h0000_0000);
        rd("trip_cnt", `FER_A_TRIP_CNT, 32'h0000_0001);
    endtask : t_mreset
    task automatic t_ar;
        ar_enabled <= 1'b1;
        repeat (2) model.fault(16'h0200, 16'h0100, 1'b1, 1'b0);
        bus(1'b0, fa(3'h0, `FER_F_MISC), 32'h0000_0000);
        chk("trip_no2", 32'h0000_0002, {24'h0, q[15:8]});
        ar_reclaim_done <= 1'b1;
        @(posedge clk);
        ar_reclaim_done <= 1'b0;
        model.fault(16'h0200, 16'h0100, 1'b1, 1'b0);
        bus(1'b0, fa(3'h0, `FER_F_MISC), 32'h0000_0000);
        chk("trip_no1", 32'h0000_0001, {24'h0, q[15:8]});
        ar_enabled <= 1'b0;
    endtask : t_ar
    task automatic t_clear;
        bus(1'b1, `FER_A_IRQ_MASK, 32'h0000_0000);
        ar_shot <= 12'h001;
        ar_open_cmd <= 1'b1;
        @(posedge clk);
        ar_shot <= 12'h000;
        ar_open_cmd <= 1'b0;
        @(posedge clk);
        rd("shots", `FER_A_SHOT_CNT, 32'h0000_0001);
        rd("opens", 7'h6A, 32'h0000_0001);
        bus(1'b1, `FER_A_CNT_CLEAR, `FER_CLR_TRIPS);
        rd("trip_cnt", `FER_A_TRIP_CNT, 32'h0000_0000);
        rd("opens", 7'h6A, 32'h0000_0000);
        rd("shots", `FER_A_SHOT_CNT, 32'h0000_0001);
        bus(1'b1, `FER_A_CNT_CLEAR, `FER_CLR_SHOTS);
        rd("shots", `FER_A_SHOT_CNT, 32'h0000_0000);
    endtask : t_clear
    initial begin
        {avs_read, avs_write, avs_address, avs_writedata, ar_open_cmd, ar_shot, mr_seen} = '0;
        {ar_enabled, ar_reclaim_done} = 2'h0;
        {rst, therm_enabled} = 2'h3;
        rtc_date = 24'h24_0611;
        rtc_time = 40'h12_3456_0789;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_start();
        t_trip();
        t_blocked();
        t_therm_off();
        t_fill_irq();
        t_mreset();
        t_ar();
        t_clear();
        close_out();
    end
endmodule : fer_recorder_tb
